// file: core/sdcb_device.sv
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
module sdcb_device (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  sdcb_if.mem bus,
  output logic [2:0] O_BANK0_STATE,
  output logic [2:0] O_BANK1_STATE,
  output logic [2:0] O_MODE,
  output logic [10:0] O_ROW0,
  output logic [10:0] O_ROW1,
  output logic [7:0] O_COL,
  output logic [11:0] O_MODE_REG,
  output logic O_REFRESH,
  output logic O_ILLEGAL
);
  sdcb_pkg::sdcb_bank_t bank_q [2];
  sdcb_pkg::sdcb_mode_t mode_q;
  logic cke_prev_q;
  logic [3:0] rec_cnt_q;
  logic [10:0] row_q [2];
  logic [7:0] col_q;
  logic [11:0] mode_reg_q;
  logic refresh_q;
  logic illegal_q;
  logic [3:0] cmd;
  logic sel;
  logic ap;
  logic both_idle;
  logic cmd_ok;

  assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
  assign sel = bus.addr[sdcb_pkg::BANK_SEL_BIT];
  assign ap = bus.addr[sdcb_pkg::AUTO_PRE_BIT];
  assign both_idle = (bank_q[0] == sdcb_pkg::SDCB_IDLE) && (bank_q[1] == sdcb_pkg::SDCB_IDLE);
  // Commands act only in normal mode with both edges enabled
  assign cmd_ok = (mode_q == sdcb_pkg::SDCB_MODE_NORMAL) && cke_prev_q;

  function automatic logic is_quiet(input logic [3:0] c);
    is_quiet = c[3] || (c[2] && c[1]);
  endfunction

  // clocked wake
  // Model of the wake: cke seen at the very edge it rises, so exit needs no prior edge.
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      cke_prev_q <= 1'b1;
    end else begin
      cke_prev_q <= bus.cke;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      mode_q <= sdcb_pkg::SDCB_MODE_NORMAL;
      rec_cnt_q <= 4'h0;
    end else begin
      unique case (mode_q)
        sdcb_pkg::SDCB_MODE_NORMAL: begin
          if (cke_prev_q && !bus.cke && both_idle) begin
            if (!bus.cs_n && cmd[2:0] == sdcb_pkg::CMD_REF[2:0]) begin
              mode_q <= sdcb_pkg::SDCB_MODE_SELF_REFRESH;
            end else begin
              mode_q <= sdcb_pkg::SDCB_MODE_POWER_DOWN;
            end
          end else if (cke_prev_q && !bus.cke) begin
            mode_q <= sdcb_pkg::SDCB_MODE_SUSPEND;
          end else if (!cke_prev_q && !bus.cke && both_idle) begin
            mode_q <= sdcb_pkg::SDCB_MODE_POWER_DOWN;
          end
        end
        sdcb_pkg::SDCB_MODE_SELF_REFRESH: begin
          if (bus.cke) begin
            mode_q <= sdcb_pkg::SDCB_MODE_SR_RECOVERY;
            rec_cnt_q <= sdcb_pkg::RECOVERY_CYC;
          end
        end
        sdcb_pkg::SDCB_MODE_SR_RECOVERY: begin
          if (!bus.cke) begin
            mode_q <= sdcb_pkg::SDCB_MODE_POWER_DOWN;
          end else if (rec_cnt_q <= 4'h1) begin
            mode_q <= sdcb_pkg::SDCB_MODE_NORMAL;
            rec_cnt_q <= 4'h0;
          end else begin
            rec_cnt_q <= rec_cnt_q - 4'h1;
          end
        end
        sdcb_pkg::SDCB_MODE_POWER_DOWN: begin
          if (bus.cke) begin
            mode_q <= sdcb_pkg::SDCB_MODE_NORMAL;
          end
        end
        sdcb_pkg::SDCB_MODE_SUSPEND: begin
          if (bus.cke) begin
            mode_q <= sdcb_pkg::SDCB_MODE_NORMAL;
          end
        end
        default: mode_q <= sdcb_pkg::SDCB_MODE_NORMAL;
      endcase
    end
  end

  for (genvar b = 0; b < 2; b++) begin : g_bank
    always_ff @(posedge I_REF_CLK) begin
      if (I_RST) begin
        bank_q[b] <= sdcb_pkg::SDCB_IDLE;
        row_q[b] <= 11'h000;
      end else if (cmd_ok && bus.cke) begin
        unique case (cmd)
          sdcb_pkg::CMD_ACT: begin
            if (sel == b[0] && bank_q[b] == sdcb_pkg::SDCB_IDLE) begin
              bank_q[b] <= sdcb_pkg::SDCB_ACTIVE;
              row_q[b] <= bus.addr[sdcb_pkg::ROW_W-1:0];
            end
          end
          sdcb_pkg::CMD_READ, sdcb_pkg::CMD_WRITE: begin
            if (sel == b[0] && bank_q[b] != sdcb_pkg::SDCB_IDLE) begin
              if (cmd == sdcb_pkg::CMD_READ) begin
                bank_q[b] <= ap ? sdcb_pkg::SDCB_READ_AP : sdcb_pkg::SDCB_READ;
              end else begin
                bank_q[b] <= ap ? sdcb_pkg::SDCB_WRITE_AP : sdcb_pkg::SDCB_WRITE;
              end
            end else if (sel != b[0] && (bank_q[b] == sdcb_pkg::SDCB_READ ||
                bank_q[b] == sdcb_pkg::SDCB_WRITE)) begin
              bank_q[b] <= sdcb_pkg::SDCB_ACTIVE;
            end
          end
          sdcb_pkg::CMD_PRE: begin
            if (ap || sel == b[0]) begin
              bank_q[b] <= sdcb_pkg::SDCB_IDLE;
            end
          end
          sdcb_pkg::CMD_BST: begin
            if (bank_q[b] == sdcb_pkg::SDCB_READ || bank_q[b] == sdcb_pkg::SDCB_WRITE) begin
              bank_q[b] <= sdcb_pkg::SDCB_ACTIVE;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      col_q <= 8'h00;
      mode_reg_q <= 12'h000;
      refresh_q <= 1'b0;
    end else begin
      refresh_q <= 1'b0;
      if (cmd_ok && bus.cke) begin
        if (cmd == sdcb_pkg::CMD_READ || cmd == sdcb_pkg::CMD_WRITE) begin
          col_q <= bus.addr[sdcb_pkg::COL_W-1:0];
        end
        if (both_idle && cmd == sdcb_pkg::CMD_MRS) begin
          mode_reg_q <= bus.addr;
        end
        if (both_idle && cmd == sdcb_pkg::CMD_REF) begin
          refresh_q <= 1'b1;
        end
      end
    end
  end

  // Flags commands the controller must never present
  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      illegal_q <= 1'b0;
    end else begin
      illegal_q <= 1'b0;
      if (mode_q == sdcb_pkg::SDCB_MODE_SR_RECOVERY && !is_quiet(cmd)) begin
        illegal_q <= 1'b1;
      end
      if (mode_q == sdcb_pkg::SDCB_MODE_SELF_REFRESH && bus.cke && !is_quiet(cmd)) begin
        illegal_q <= 1'b1;
      end
      if (cmd_ok && bus.cke && !both_idle && !bus.cs_n && cmd[2:1] == 2'h0) begin
        illegal_q <= 1'b1;
      end
    end
  end

  assign O_BANK0_STATE = bank_q[0];
  assign O_BANK1_STATE = bank_q[1];
  assign O_MODE = mode_q;
  assign O_ROW0 = row_q[0];
  assign O_ROW1 = row_q[1];
  assign O_COL = col_q;
  assign O_MODE_REG = mode_reg_q;
  assign O_REFRESH = refresh_q;
  assign O_ILLEGAL = illegal_q;
endmodule

// file: core/sdcb_pkg.sv
package sdcb_pkg;
  // Address pin positions
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_SEL_BIT = 11;
  localparam int unsigned AUTO_PRE_BIT = 10;
  localparam int unsigned COL_W = 8;
  localparam int unsigned ROW_W = 11;
  // Command pin encodings {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_READ = 4'h5;
  localparam logic [3:0] CMD_WRITE = 4'h4;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_DESELECT_CMD = 4'hf;
  // Recovery count after self-refresh exit, in cycles
  localparam int unsigned RECOVERY_NS = 60;
  localparam int unsigned CLK_NS = 20;
  localparam logic [3:0] RECOVERY_CYC = 4'((RECOVERY_NS + CLK_NS - 1) / CLK_NS);
  // APB register offsets of the controller
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
  // Command register fields
  localparam int unsigned CKE_BIT = 16;
  localparam int unsigned CMD_LSB = 12;

  typedef enum logic [2:0] {
    SDCB_IDLE,
    SDCB_ACTIVE,
    SDCB_READ,
    SDCB_WRITE,
    SDCB_READ_AP,
    SDCB_WRITE_AP
  } sdcb_bank_t;

  typedef enum logic [2:0] {
    SDCB_MODE_NORMAL,
    SDCB_MODE_SELF_REFRESH,
    SDCB_MODE_SR_RECOVERY,
    SDCB_MODE_POWER_DOWN,
    SDCB_MODE_SUSPEND
  } sdcb_mode_t;
endpackage

// file: core/sdcb_if.sv
`timescale 1ns/1ps
interface sdcb_if;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [11:0] addr;
  modport ctrl (output cke, output cs_n, output ras_n, output cas_n, output we_n, output addr);
  modport mem (input cke, input cs_n, input ras_n, input cas_n, input we_n, input addr);
endinterface

// file: core/sdcb_ctrl.sv
`timescale 1ns/1ps
// Controller: software writes {cke, cmd[3:0], addr[11:0]} to the command register;
// the command is driven on the pins for one cycle, then no-operation follows.
module sdcb_ctrl (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  sdcb_if.ctrl bus
);
  logic cke_q;
  logic [3:0] cmd_q;
  logic [11:0] addr_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [15:0] issued_q;
  logic setup;

  assign setup = I_PSEL && !I_PENABLE;

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      cke_q <= 1'b1;
      cmd_q <= sdcb_pkg::CMD_NOP;
      addr_q <= 12'h000;
      issued_q <= 16'h0000;
    end else if (setup && I_PWRITE && I_PADDR == sdcb_pkg::REG_CMD) begin
      cke_q <= I_PWDATA[sdcb_pkg::CKE_BIT];
      cmd_q <= I_PWDATA[sdcb_pkg::CMD_LSB +: 4];
      addr_q <= I_PWDATA[sdcb_pkg::ADDR_W-1:0];
      issued_q <= issued_q + 16'h0001;
    end else begin
      cmd_q <= sdcb_pkg::CMD_NOP;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    if (I_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= sdcb_pkg::STATUS_RESET;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && I_PADDR != sdcb_pkg::REG_CMD && I_PADDR != sdcb_pkg::REG_STATUS;
      if (setup && !I_PWRITE) begin
        prdata_q <= (I_PADDR == sdcb_pkg::REG_STATUS) ? {15'h0000, cke_q, issued_q} : 32'h0;
      end
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign bus.cke = cke_q;
  assign bus.cs_n = cmd_q[3];
  assign bus.ras_n = cmd_q[2];
  assign bus.cas_n = cmd_q[1];
  assign bus.we_n = cmd_q[0];
  assign bus.addr = addr_q;
endmodule

// file: verification/sdcb_props.sv
`timescale 1ns/1ps
module sdcb_props (
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [11:0] addr,
  input wire logic [2:0] O_BANK0_STATE,
  input wire logic [2:0] O_BANK1_STATE,
  input wire logic [2:0] O_MODE,
  input wire logic [11:0] O_MODE_REG,
  input wire logic O_REFRESH
);
  logic [3:0] c;
  logic pc_q;
  logic on;
  logic i0;
  logic i1;
  logic nrm;
  default clocking @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  assign c = {cs_n, ras_n, cas_n, we_n};
  assign nrm = O_MODE == sdcb_pkg::SDCB_MODE_NORMAL;
  // A command counts only with enable high on two edges
  assign on = pc_q && cke && nrm;
  assign i0 = O_BANK0_STATE == sdcb_pkg::SDCB_IDLE;
  assign i1 = O_BANK1_STATE == sdcb_pkg::SDCB_IDLE;
  always_ff @(posedge I_REF_CLK) begin
    pc_q <= !I_RST && cke;
  end
  property p_act;
    on && c == sdcb_pkg::CMD_ACT && !addr[11] && i0
      |=> O_BANK0_STATE == sdcb_pkg::SDCB_ACTIVE && $stable(O_BANK1_STATE);
  endproperty
  a_act: assert property (p_act) else $error("bank 0 not opened");
  property p_rd;
    on && c == sdcb_pkg::CMD_READ && addr[11] && O_BANK1_STATE == sdcb_pkg::SDCB_ACTIVE
      |=> O_BANK1_STATE == ($past(addr[10]) ? sdcb_pkg::SDCB_READ_AP : sdcb_pkg::SDCB_READ);
  endproperty
  a_rd: assert property (p_rd) else $error("bank 1 read state wrong");
  property p_pall;
    on && c == sdcb_pkg::CMD_PRE && addr[10] |=> i0 && i1;
  endproperty
  a_pall: assert property (p_pall) else $error("banks not idled");
  property p_ref;
    on && c == sdcb_pkg::CMD_REF && i0 && i1 |=> O_REFRESH && i0 && i1;
  endproperty
  a_ref: assert property (p_ref) else $error("refresh not seen");
  property p_mrs;
    on && c == sdcb_pkg::CMD_MRS && i0 && i1 |=> O_MODE_REG == $past(addr) && i0 && i1;
  endproperty
  a_mrs: assert property (p_mrs) else $error("mode load wrong");
  property p_nop;
    on && (cs_n || c == sdcb_pkg::CMD_NOP) |=> $stable(O_BANK0_STATE) && $stable(O_BANK1_STATE);
  endproperty
  a_nop: assert property (p_nop) else $error("idle command moved a bank");
  property p_hold;
    !cke |=> $stable(O_BANK0_STATE) && $stable(O_BANK1_STATE);
  endproperty
  a_hold: assert property (p_hold) else $error("bank moved with enable low");
  property p_susp;
    pc_q && !cke && nrm && !(i0 && i1) |=> O_MODE == sdcb_pkg::SDCB_MODE_SUSPEND;
  endproperty
  a_susp: assert property (p_susp) else $error("no clock suspend");
  c_act: cover property (on && c == sdcb_pkg::CMD_ACT);
  c_susp: cover property (O_MODE == sdcb_pkg::SDCB_MODE_SUSPEND);
  c_self: cover property (O_MODE == sdcb_pkg::SDCB_MODE_SELF_REFRESH);
endmodule

// file: verification/sdram_cke_and_bank_command_fsm_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin samples_checked++; if ((e) !== (s)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, e, s); end end
module sdram_cke_and_bank_command_fsm_tb_top;
  localparam sdcb_pkg::sdcb_bank_t IDL = sdcb_pkg::SDCB_IDLE;
  localparam sdcb_pkg::sdcb_bank_t OPN = sdcb_pkg::SDCB_ACTIVE;
  localparam sdcb_pkg::sdcb_bank_t RD = sdcb_pkg::SDCB_READ;
  localparam sdcb_pkg::sdcb_bank_t WR = sdcb_pkg::SDCB_WRITE;
  localparam sdcb_pkg::sdcb_bank_t RDA = sdcb_pkg::SDCB_READ_AP;
  localparam sdcb_pkg::sdcb_bank_t WRA = sdcb_pkg::SDCB_WRITE_AP;
  logic ck = 1'b0;
  logic rs = 1'b1;
  logic ps = 1'b0;
  logic pe = 1'b0;
  logic pw = 1'b0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pd = 32'h0;
  logic [31:0] prd, r;
  logic rdy, perr, x, refr, ill;
  logic [2:0] b0, b1, md;
  logic [10:0] row0, row1;
  logic [7:0] col;
  logic [11:0] mreg, v;
  logic [5:0] e;
  logic [5:0] expq[$];
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  int ncmd = 0;
  int nill = 0;
  sdcb_if bus ();
  sdcb_ctrl u_sdcb_ctrl (.I_REF_CLK(ck), .I_RST(rs), .I_PSEL(ps), .I_PENABLE(pe),
    .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prd), .O_PREADY(rdy),
    .O_PSLVERR(perr), .bus(bus));
  sdcb_device u_sdcb_device (.I_REF_CLK(ck), .I_RST(rs), .bus(bus), .O_BANK0_STATE(b0),
    .O_BANK1_STATE(b1), .O_MODE(md), .O_ROW0(row0), .O_ROW1(row1), .O_COL(col),
    .O_MODE_REG(mreg), .O_REFRESH(refr), .O_ILLEGAL(ill));
  sdcb_props u_sdcb_props (.I_REF_CLK(ck), .I_RST(rs), .cke(bus.cke), .cs_n(bus.cs_n),
    .ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .addr(bus.addr),
    .O_BANK0_STATE(b0), .O_BANK1_STATE(b1), .O_MODE(md), .O_MODE_REG(mreg), .O_REFRESH(refr));
  always #10 ck = ~ck;
  always @(posedge ck) begin
    cyc++;
    // Illegal flag pulses for one cycle, so each pulse is counted once
    if (ill === 1'b1) begin
      nill++;
    end
    if (cyc == 3000) begin
      err_total++;
      complete_run();
    end
  end
  // Bank states settle one edge after the pins carried the command
  always @(posedge ck) begin
    if (ps && pe && rdy && pw && pa == 8'h00) begin
      #1;
      e = expq.size() > 0 ? expq.pop_front() : 6'h3f;
      `CHK("banks", e, {b0, b1})
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    ps <= 1'b1;
    pw <= w;
    pa <= a;
    pd <= d;
    @(posedge ck);
    pe <= 1'b1;
    @(posedge ck);
    while (rdy !== 1'b1) @(posedge ck);
    r = prd;
    x = perr;
    ps <= 1'b0;
    pe <= 1'b0;
    @(posedge ck);
  endtask
  task automatic cmd(input logic k, input logic [3:0] c, input logic [11:0] a,
      input sdcb_pkg::sdcb_bank_t e0, input sdcb_pkg::sdcb_bank_t e1);
    expq.push_back({e0, e1});
    ncmd++;
    apb(1'b1, 8'h00, {15'h0, k, c, a});
  endtask
  task automatic stat(input logic k, input sdcb_pkg::sdcb_mode_t m);
    apb(1'b0, 8'h04, 32'h0);
    `CHK("status", {15'h0, k, 16'(ncmd)}, r)
    `CHK("mode", m, md)
  endtask
  initial begin
    void'($urandom(32'h2b157b8e));
    repeat (2) @(posedge ck);
    rs <= 1'b0;
    @(posedge ck);
    v = 12'($urandom());
    cmd(1'b1, sdcb_pkg::CMD_MRS, v, IDL, IDL);
    `CHK("mode reg", v, mreg)
    cmd(1'b1, sdcb_pkg::CMD_REF, v, IDL, IDL);
    cmd(1'b1, sdcb_pkg::CMD_ACT, {1'b0, v[10:0]}, OPN, IDL);
    `CHK("row", v[10:0], row0)
    cmd(1'b1, sdcb_pkg::CMD_ACT, {1'b1, ~v[10:0]}, OPN, OPN);
    `CHK("row1", ~v[10:0], row1)
    cmd(1'b1, sdcb_pkg::CMD_READ, {4'h7, v[7:0]}, RDA, OPN);
    `CHK("column", v[7:0], col)
    cmd(1'b1, sdcb_pkg::CMD_WRITE, 12'hb00, RDA, WR);
    cmd(1'b1, sdcb_pkg::CMD_PRE, 12'h000, IDL, WR);
    cmd(1'b1, sdcb_pkg::CMD_BST, v, IDL, OPN);
    cmd(1'b1, sdcb_pkg::CMD_READ, 12'h800, IDL, RD);
    cmd(1'b1, sdcb_pkg::CMD_WRITE, 12'hc00, IDL, WRA);
    cmd(1'b1, sdcb_pkg::CMD_NOP, v, IDL, WRA);
    cmd(1'b1, sdcb_pkg::CMD_DESELECT_CMD, v, IDL, WRA);
    cmd(1'b1, sdcb_pkg::CMD_PRE, 12'h400, IDL, IDL);
    cmd(1'b1, sdcb_pkg::CMD_ACT, 12'h000, OPN, IDL);
    cmd(1'b0, sdcb_pkg::CMD_NOP, 12'h000, OPN, IDL);
    stat(1'b0, sdcb_pkg::SDCB_MODE_SUSPEND);
    cmd(1'b0, sdcb_pkg::CMD_ACT, 12'h800, OPN, IDL);
    cmd(1'b1, sdcb_pkg::CMD_NOP, 12'h000, OPN, IDL);
    stat(1'b1, sdcb_pkg::SDCB_MODE_NORMAL);
    cmd(1'b1, sdcb_pkg::CMD_PRE, 12'h400, IDL, IDL);
    cmd(1'b0, sdcb_pkg::CMD_REF, 12'h000, IDL, IDL);
    stat(1'b0, sdcb_pkg::SDCB_MODE_SELF_REFRESH);
    cmd(1'b1, sdcb_pkg::CMD_NOP, 12'h000, IDL, IDL);
    cmd(1'b0, sdcb_pkg::CMD_NOP, 12'h000, IDL, IDL);
    stat(1'b0, sdcb_pkg::SDCB_MODE_POWER_DOWN);
    cmd(1'b0, sdcb_pkg::CMD_ACT, 12'h000, IDL, IDL);
    cmd(1'b1, sdcb_pkg::CMD_NOP, 12'h000, IDL, IDL);
    stat(1'b1, sdcb_pkg::SDCB_MODE_NORMAL);
    cmd(1'b0, sdcb_pkg::CMD_REF, 12'h000, IDL, IDL);
    cmd(1'b1, sdcb_pkg::CMD_NOP, 12'h000, IDL, IDL);
    stat(1'b1, sdcb_pkg::SDCB_MODE_NORMAL);
    cmd(1'b1, sdcb_pkg::CMD_ACT, 12'h800, IDL, OPN);
    cmd(1'b1, sdcb_pkg::CMD_REF, 12'h000, IDL, OPN);
    apb(1'b1, 8'h08, 32'h0);
    `CHK("slave error", 1'b1, x)
    `CHK("illegal", 1, nill)
    complete_run();
  end
endmodule
